// [src/sas_pkg.sv]
// sas_pkg: constants shared by the converter sequencer and its helpers
// assumes a single 20 MHz clock and word-aligned wishbone register access
package sas_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_PORT_A_PINS      = 8'h05;
	localparam logic [7:0] IDX_GLOBAL_IRQ_CTRL  = 8'h0B;
	localparam logic [7:0] IDX_PERIPH_IRQ_FLAGS = 8'h0C;
	localparam logic [7:0] IDX_CONV_RESULT      = 8'h1E;
	localparam logic [7:0] IDX_CONV_CONTROL     = 8'h1F;
	localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'h85;
	localparam logic [7:0] IDX_PERIPH_IRQ_ENS   = 8'h8C;
	localparam logic [7:0] IDX_ANALOG_PIN_CFG   = 8'h9F;
	// reset values
	localparam logic [7:0] RST_CONV_CONTROL     = 8'h00;
	localparam logic [5:0] RST_PORT_A_DIRECTION = 6'h3F;
	localparam logic [2:0] RST_ANALOG_PIN_CFG   = 3'h0;
	localparam logic [7:0] RST_GLOBAL_IRQ_CTRL  = 8'h00;
	// field positions
	localparam int CTL_CLK_SEL_LSB = 6;
	localparam int CTL_CHAN_LSB    = 3;
	localparam int CTL_BUSY_BIT    = 2;
	localparam int CTL_POWER_BIT   = 0;
	localparam int CONV_IRQ_BIT    = 6;
	localparam int GLB_GIE_BIT     = 7;
	localparam int GLB_PERIPH_GROUP_IRQ_ENABLE_BIT    = 6;
	// compare unit mode that fires the special event trigger
	localparam logic [3:0] CMP_MODE_SPECIAL = 4'hB;
	// timing: conv_bit_period in clock cycles, counted in half periods
	localparam int CLK_PERIOD_NS   = 50;
	localparam int RC_TAD_NS       = 4000;
	localparam int HALF_2TOSC      = 1;
	localparam int HALF_8TOSC      = 4;
	localparam int HALF_32TOSC     = 16;
	localparam int HALF_RC         = RC_TAD_NS / CLK_PERIOD_NS / 2;
	// 9.5 conv_bit_period per conversion, 1.5 of them before the first trial
	localparam logic [4:0] HALVES_SETUP = 5'h03;
	localparam logic [4:0] HALVES_TOTAL = 5'h13;
	// pins treated as analog for each pin_analog_config code
	localparam logic [47:0] ANALOG_MASK_LUT = {6'h00, 6'h00, 6'h01, 6'h03,
		6'h0B, 6'h0F, 6'h2F, 6'h2F};
	typedef enum logic [1:0] {
		SAS_IDLE  = 2'b00,
		SAS_SETUP = 2'b01,
		SAS_BITS  = 2'b11,
		SAS_DONE  = 2'b10
	} sas_state_e;
endpackage

// [src/sas_tad_gen.sv]
// sas_tad_gen: half conv_bit_period tick generator
// assumes run_i stays high for the whole conversion; restarts phase on run
`timescale 1ns/10ps
module sas_tad_gen (
	// clock and reset
	input  logic       clk_i,
	input  logic       rst_i,
	// control
	input  logic       run_i,
	input  logic [1:0] sel_i,
	// tick
	output logic       half_tick_o
);
	logic [5:0] cnt;
	logic [5:0] reload;

	// rc source is modelled as a fixed count of the main clock
	assign reload = (sel_i == 2'b00) ? 6'(sas_pkg::HALF_2TOSC - 1) :
		(sel_i == 2'b01) ? 6'(sas_pkg::HALF_8TOSC - 1) :
		(sel_i == 2'b10) ? 6'(sas_pkg::HALF_32TOSC - 1) :
		6'(sas_pkg::HALF_RC - 1);

	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			cnt         <= reload;
			half_tick_o <= 1'b0;
		end else if (cnt == 6'h00) begin
			cnt         <= reload;
			half_tick_o <= 1'b1;
		end else begin
			cnt         <= cnt - 6'h01;
			half_tick_o <= 1'b0;
		end
	end
endmodule // sas_tad_gen

// [src/sas_sar.sv]
// sas_sar: successive approximation sequencer, one trial bit per period
// assumes comp_i is high when the held input is at or above dac_o
`timescale 1ns/10ps
module sas_sar (
	// clock and reset
	input  logic       clk_i,
	input  logic       rst_i,
	// control
	input  logic       start_i,
	input  logic       abort_i,
	input  logic       half_tick_i,
	// comparator
	input  logic       comp_i,
	// status and data
	output logic       busy_o,
	output logic       done_o,
	output logic [7:0] dac_o
);
	sas_pkg::sas_state_e state;
	logic [4:0]          halves;
	logic [2:0]          bit_idx;
	wire  [4:0]          next_halves = halves + 5'h01;

	always_ff @(posedge clk_i) begin
		if (rst_i || abort_i) begin
			state   <= sas_pkg::SAS_IDLE;
			halves  <= 5'h00;
			bit_idx <= 3'h7;
			busy_o  <= 1'b0;
			done_o  <= 1'b0;
			dac_o   <= 8'h00;
		end else begin
			done_o <= 1'b0;
			case (state)
				sas_pkg::SAS_IDLE: begin
					if (start_i) begin
						state   <= sas_pkg::SAS_SETUP;
						busy_o  <= 1'b1;
						halves  <= 5'h00;
						bit_idx <= 3'h7;
						dac_o   <= 8'h00;
					end
				end
				sas_pkg::SAS_SETUP: begin
					if (half_tick_i) begin
						halves <= next_halves;
						if (next_halves == sas_pkg::HALVES_SETUP) begin
							state          <= sas_pkg::SAS_BITS;
							dac_o[bit_idx] <= 1'b1;
						end
					end
				end
				sas_pkg::SAS_BITS: begin
					if (half_tick_i) begin
						halves <= next_halves;
						if (next_halves == sas_pkg::HALVES_TOTAL) begin
							state <= sas_pkg::SAS_DONE;
						end else if (next_halves[0]) begin
							dac_o[bit_idx] <= 1'b1;
						end else begin
							// decide the bit half a period after its trial was set
							dac_o[bit_idx] <= comp_i;
							bit_idx        <= bit_idx - 3'h1;
						end
					end
				end
				sas_pkg::SAS_DONE: begin
					state  <= sas_pkg::SAS_IDLE;
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end
				default: begin
					state  <= sas_pkg::SAS_IDLE;
					busy_o <= 1'b0;
				end
			endcase
		end
	end
endmodule // sas_sar

// [src/sas_top.sv]
// sas_top: sequencer for an 8-bit successive approximation converter
// assumes an outside comparator, sample switch and 16-bit timer
//
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
module sas_top (
	// clock and reset
	input  logic        clk_i,
	input  logic        rst_i,
	// wishbone slave
	input  logic        cyc_i,
	input  logic        stb_i,
	input  logic        we_i,
	input  logic [9:0]  adr_i,
	input  logic [3:0]  sel_i,
	input  logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic        ack_o,
	// port a pins
	input  logic [5:0]  pin_i,
	output logic [5:0]  pin_o,
	output logic [5:0]  pin_oe_n_o,
	// analog front end
	input  logic        comp_i,
	output logic [5:0]  channel_pin_o,
	output logic        hold_connect_o,
	output logic [7:0]  dac_code_o,
	// compare unit and timer
	input  logic        trig_i,
	input  logic [3:0]  compare_mode_i,
	output logic        timer_clear_o,
	// interrupt request
	output logic        irq_o
);
	// registers
	logic [1:0] conv_clock_select;
	logic [2:0] channel_select;
	logic       conv_power_on;
	logic [7:0] conv_result;
	logic [2:0] pin_analog_config;
	logic [5:0] port_a_pins;
	logic [5:0] port_a_direction;
	logic [7:0] global_irq_control;
	logic       conv_irq_flag;
	logic       conv_irq_enable;

	// converter core
	logic       half_tick;
	logic       sar_busy;
	logic       sar_done;
	logic [7:0] sar_code;

	// bus decode
	wire        bus_req   = cyc_i && stb_i;
	wire        bus_write = bus_req && we_i && ack_o && sel_i[0];
	wire        aligned   = (adr_i[1:0] == 2'b00);
	wire  [7:0] reg_idx   = adr_i[9:2];
	wire  [7:0] wdat      = dat_i[7:0];

	wire hit_port = aligned && (reg_idx == sas_pkg::IDX_PORT_A_PINS);
	wire hit_glb  = aligned && (reg_idx == sas_pkg::IDX_GLOBAL_IRQ_CTRL);
	wire hit_flag = aligned && (reg_idx == sas_pkg::IDX_PERIPH_IRQ_FLAGS);
	wire hit_res  = aligned && (reg_idx == sas_pkg::IDX_CONV_RESULT);
	wire hit_ctl  = aligned && (reg_idx == sas_pkg::IDX_CONV_CONTROL);
	wire hit_dir  = aligned && (reg_idx == sas_pkg::IDX_PORT_A_DIRECTION);
	wire hit_ens  = aligned && (reg_idx == sas_pkg::IDX_PERIPH_IRQ_ENS);
	wire hit_cfg  = aligned && (reg_idx == sas_pkg::IDX_ANALOG_PIN_CFG);

	wire wr_port = bus_write && hit_port;
	wire wr_glb  = bus_write && hit_glb;
	wire wr_flag = bus_write && hit_flag;
	wire wr_ctl  = bus_write && hit_ctl;
	wire wr_dir  = bus_write && hit_dir;
	wire wr_ens  = bus_write && hit_ens;
	wire wr_cfg  = bus_write && hit_cfg;

	// control word fields of a write
	wire       wr_busy  = wdat[sas_pkg::CTL_BUSY_BIT];
	wire       wr_power = wdat[sas_pkg::CTL_POWER_BIT];

	// analog pin mask from the pin configuration
	wire [5:0] analog_mask = sas_pkg::ANALOG_MASK_LUT[pin_analog_config * 6 +: 6];

	// port read: analog pins read low
	wire [5:0] port_read = pin_i & ~analog_mask;

	// start sources; the trigger exists only in the special compare mode
	wire special_trig = trig_i && (compare_mode_i == sas_pkg::CMP_MODE_SPECIAL);
	// software start needs the converter already on, not powered in this write
	wire sw_start  = wr_ctl && wr_busy && conv_power_on && !sar_busy;
	// trigger starts a conversion only when powered
	wire trg_start = special_trig && conv_power_on && !sar_busy;
	wire conv_start = sw_start || trg_start;

	// power off or a busy bit written low aborts the conversion
	wire conv_abort = wr_ctl && (!wr_power || !wr_busy) && sar_busy;

	// read mux
	wire [7:0] ctl_read = {conv_clock_select, channel_select, sar_busy, 1'b0,
		conv_power_on};
	wire [7:0] rd_byte =
		hit_port ? {2'b00, port_read} :
		hit_glb  ? global_irq_control :
		hit_flag ? {1'b0, conv_irq_flag, 6'h00} :
		hit_res  ? conv_result :
		hit_ctl  ? ctl_read :
		hit_dir  ? {2'b00, port_a_direction} :
		hit_ens  ? {1'b0, conv_irq_enable, 6'h00} :
		hit_cfg  ? {5'h00, pin_analog_config} :
		8'h00;

	// one-hot channel routing; code 100 reaches the sixth pin
	wire [5:0] next_channel_pin =
		(channel_select == 3'h0) ? 6'h01 :
		(channel_select == 3'h1) ? 6'h02 :
		(channel_select == 3'h2) ? 6'h04 :
		(channel_select == 3'h3) ? 6'h08 :
		(channel_select == 3'h4) ? 6'h20 :
		6'h00;

	// interrupt gating
	wire next_irq = conv_irq_flag && conv_irq_enable
		&& global_irq_control[sas_pkg::GLB_GIE_BIT]
		&& global_irq_control[sas_pkg::GLB_PERIPH_GROUP_IRQ_ENABLE_BIT];

	// flag: a completion in the same cycle as a clear still sets it
	wire next_flag = sar_done ? 1'b1 :
		(wr_flag ? wdat[sas_pkg::CONV_IRQ_BIT] : conv_irq_flag);

	// bus handshake: answer one cycle after the request, drop after one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= bus_req && !ack_o;
			dat_o <= {24'h00_0000, rd_byte};
		end
	end

	// converter control register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_clock_select <= sas_pkg::RST_CONV_CONTROL[sas_pkg::CTL_CLK_SEL_LSB +: 2];
			channel_select    <= sas_pkg::RST_CONV_CONTROL[sas_pkg::CTL_CHAN_LSB +: 3];
			conv_power_on     <= sas_pkg::RST_CONV_CONTROL[sas_pkg::CTL_POWER_BIT];
		end else if (wr_ctl) begin
			conv_clock_select <= wdat[sas_pkg::CTL_CLK_SEL_LSB +: 2];
			channel_select    <= wdat[sas_pkg::CTL_CHAN_LSB +: 3];
			conv_power_on     <= wr_power;
		end
	end

	// pin configuration and port registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_analog_config <= sas_pkg::RST_ANALOG_PIN_CFG;
			port_a_direction  <= sas_pkg::RST_PORT_A_DIRECTION;
			port_a_pins       <= 6'h00;
		end else begin
			if (wr_cfg) begin
				pin_analog_config <= wdat[2:0];
			end
			if (wr_dir) begin
				port_a_direction <= wdat[5:0];
			end
			if (wr_port) begin
				port_a_pins <= wdat[5:0];
			end
		end
	end

	// interrupt registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			global_irq_control <= sas_pkg::RST_GLOBAL_IRQ_CTRL;
			conv_irq_flag      <= 1'b0;
			conv_irq_enable    <= 1'b0;
		end else begin
			conv_irq_flag <= next_flag;
			if (wr_glb) begin
				global_irq_control <= wdat;
			end
			if (wr_ens) begin
				conv_irq_enable <= wdat[sas_pkg::CONV_IRQ_BIT];
			end
		end
	end

	// result keeps its content through reset
	always_ff @(posedge clk_i) begin
		if (sar_done) begin
			conv_result <= sar_code;
		end
	end

	// pin and front-end outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_o          <= 6'h00;
			pin_oe_n_o     <= sas_pkg::RST_PORT_A_DIRECTION;
			channel_pin_o  <= 6'h01;
			hold_connect_o <= 1'b0;
			timer_clear_o  <= 1'b0;
			irq_o          <= 1'b0;
		end else begin
			// drivers stay on regardless of analog use, so a driven level converts
			pin_o          <= port_a_pins;
			pin_oe_n_o     <= port_a_direction;
			channel_pin_o  <= next_channel_pin;
			// capacitor held off the pin from start to completion
			hold_connect_o <= conv_power_on && !sar_busy && !conv_start;
			// the timer clear ignores the power state
			timer_clear_o  <= special_trig;
			irq_o          <= next_irq;
		end
	end

	// bit period clock
	sas_tad_gen u_tad (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.run_i       (sar_busy),
		.sel_i       (conv_clock_select),
		.half_tick_o (half_tick)
	);

	// approximation engine: 19 half periods per conversion
	sas_sar u_sar (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.start_i     (conv_start),
		.abort_i     (conv_abort),
		.half_tick_i (half_tick),
		.comp_i      (comp_i),
		.busy_o      (sar_busy),
		.done_o      (sar_done),
		.dac_o       (sar_code)
	);

	// trial code straight from the engine's register: an extra stage would make
	// the 2-clock bit period decide each bit against the previous trial
	assign dac_code_o = sar_code;
endmodule // sas_top

// [dv/sas_analog_src.sv]
// sas_analog_src: six pin levels behind the sample switch, and a comparator
// assumes a one-hot pin select and the design's registered trial code
`timescale 1ns/10ps
module sas_analog_src (
	// clock
	input  logic        clk_i,
	// levels, eight bits per pin
	input  logic [47:0] level_i,
	// front end
	input  logic [5:0]  channel_pin_i,
	input  logic        hold_connect_i,
	input  logic [7:0]  dac_code_i,
	output logic        comp_o
);
	logic [7:0] held;

	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 6; i++) begin
			// held level freezes once the switch opens
			if (hold_connect_i && channel_pin_i[i]) begin
				held <= level_i[i*8 +: 8];
			end
		end
	end

	// unknown until a first acquisition, as on a cold capacitor
	assign comp_o = held >= dac_code_i;
endmodule // sas_analog_src

// [dv/sas_monitor.sv]
// sas_monitor: port assertions for the converter sequencer
// assumes it is bound to sas_top and sees only its ports
`timescale 1ns/10ps
module sas_monitor (
	// clock and reset
	input  logic        clk_i,
	input  logic        rst_i,
	// bus
	input  logic        cyc_i,
	input  logic        stb_i,
	input  logic        we_i,
	input  logic [9:0]  adr_i,
	input  logic [3:0]  sel_i,
	input  logic [31:0] dat_i,
	input  logic [31:0] dat_o,
	input  logic        ack_o,
	// pins and front end
	input  logic [5:0]  pin_oe_n_o,
	input  logic [5:0]  channel_pin_o,
	input  logic        hold_connect_o,
	// compare unit
	input  logic        trig_i,
	input  logic [3:0]  compare_mode_i,
	input  logic        timer_clear_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire wr_ack = cyc_i & stb_i & we_i & ack_o & sel_i[0];

	sequence s_start;
		wr_ack && adr_i == {sas_pkg::IDX_CONV_CONTROL, 2'b00} && dat_i[2] && dat_i[0]
			&& hold_connect_o;
	endsequence
	sequence s_trig;
		trig_i && compare_mode_i == sas_pkg::CMP_MODE_SPECIAL;
	endsequence

	property p_ack_once; ack_o |=> !ack_o; endproperty
	property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
	property p_rd_high; ack_o |-> dat_o[31:8] == 24'h0; endproperty
	property p_unmapped; ack_o && !we_i && adr_i[1:0] != 2'b00 |-> dat_o == 32'h0; endproperty
	property p_conv_hold; s_start |=> !hold_connect_o [*8]; endproperty
	property p_trig_start; s_trig ##0 hold_connect_o |=> !hold_connect_o [*4]; endproperty
	property p_clr_follow; s_trig |=> timer_clear_o; endproperty
	property p_clr_cause; timer_clear_o |-> $past(trig_i && compare_mode_i == 4'hB); endproperty
	property p_rel_vals; $fell(rst_i) |-> pin_oe_n_o == 6'h3F && !hold_connect_o; endproperty
	property p_chan; $onehot0(channel_pin_o) && !channel_pin_o[4]; endproperty
	// direction only moves on a write, and the pin enables follow one cycle later
	sequence s_no_dir_wr;
		!(wr_ack && adr_i == {sas_pkg::IDX_PORT_A_DIRECTION, 2'b00});
	endsequence
	property p_dir_hold;
		s_no_dir_wr ##1 s_no_dir_wr |=> $stable(pin_oe_n_o);
	endproperty

	a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	a_rd_high: assert property (p_rd_high) else $error("read data high bits set");
	a_unmapped: assert property (p_unmapped) else $error("misaligned read not zero");
	a_conv_hold: assert property (p_conv_hold) else $error("switch closed early");
	a_trig_start: assert property (p_trig_start) else $error("trigger ignored");
	a_clr_follow: assert property (p_clr_follow) else $error("no timer clear");
	a_clr_cause: assert property (p_clr_cause) else $error("stray timer clear");
	a_rel_vals: assert property (p_rel_vals) else $error("bad values after reset");
	a_chan: assert property (p_chan) else $error("bad pin select");
	a_dir_hold: assert property (p_dir_hold) else $error("direction changed alone");
endmodule // sas_monitor

bind sas_top sas_monitor u_mon (.*);

// [dv/testbench.sv]
// testbench: random and directed checks of the converter sequencer
// assumes the analog source model and the bound port monitor
`timescale 1ns/10ps
module testbench;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, comp_i, trig_i;
	logic        hold_connect_o, timer_clear_o, irq_o;
	logic [9:0]  adr_i;
	logic [3:0]  sel_i, compare_mode_i;
	logic [31:0] dat_i, dat_o, seed;
	logic [5:0]  pin_i, pin_o, pin_oe_n_o, channel_pin_o;
	logic [7:0]  dac_code_o, q;
	logic [47:0] level;
	int          fails, checked, t0;
	int          ncyc = 0;
	localparam logic [47:0] MASKS = {6'h00, 6'h00, 6'h01, 6'h03, 6'h0B, 6'h0F, 6'h2F, 6'h2F};
	localparam logic [9:0] CTL = {sas_pkg::IDX_CONV_CONTROL, 2'b00};
	localparam logic [9:0] FLG = {sas_pkg::IDX_PERIPH_IRQ_FLAGS, 2'b00};

	sas_top DUT (.*);
	sas_analog_src SRC (.clk_i(clk_i), .level_i(level), .channel_pin_i(channel_pin_o),
		.hold_connect_i(hold_connect_o), .dac_code_i(dac_code_o), .comp_o(comp_i));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) ncyc <= ncyc + 1;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	function automatic logic [9:0] ra(input logic [7:0] i);
		return {i, 2'b00};
	endfunction
	function automatic int halves(input logic [1:0] c);
		case (c)
			2'b00: return sas_pkg::HALF_2TOSC;
			2'b01: return sas_pkg::HALF_8TOSC;
			2'b10: return sas_pkg::HALF_32TOSC;
			default: return sas_pkg::HALF_RC;
		endcase
	endfunction

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one classic cycle; the answer is awaited, never assumed
	task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		q = dat_o[7:0];
		{cyc_i, stb_i} <= 2'b00;
		if (n >= 50) begin
			fails++;
			end_of_test();
		end
	endtask
	task automatic trg(input logic [3:0] m);
		@(posedge clk_i);
		{trig_i, compare_mode_i} <= {1'b1, m};
		@(posedge clk_i);
		trig_i <= 1'b0;
	endtask
	task automatic rst_vals();
		logic [7:0] idx [6] = '{8'h1F, 8'h85, 8'h9F, 8'h0C, 8'h8C, 8'h0B};
		logic [7:0] exp [6] = '{8'h00, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 6; i++) begin
			wb(1'b0, ra(idx[i]), 8'h00);
			chk("reset value", q, exp[i]);
		end
		$display("test reset values done");
	endtask
	task automatic conv(input logic [1:0] c, input logic by_trig);
		logic [2:0] ch;
		int h, dt, p;
		seed = xs(seed);
		ch = 3'(seed[7:0] % 8'd5);
		p = (ch == 3'd4) ? 5 : int'(ch);
		level <= {seed[15:0], seed};
		wb(1'b1, CTL, {c, ch, 3'b001});
		repeat (40) @(posedge clk_i); // acquisition after channel choice
		t0 = ncyc;
		if (by_trig) trg(sas_pkg::CMP_MODE_SPECIAL);
		else wb(1'b1, CTL, {c, ch, 3'b101});
		do begin
			wb(1'b0, CTL, 8'h00);
			dt = ncyc - t0;
		end while (q[2] && dt < 2000); // poll busy
		h = halves(c);
		chk("conversion time", 8'(dt >= 19 * h && dt <= 19 * h + 12), 8'h01);
		wb(1'b0, ra(sas_pkg::IDX_CONV_RESULT), 8'h00);
		chk("result", q, level[p*8 +: 8]);
		wb(1'b0, FLG, 8'h00);
		chk("flag", q, 8'h40);
		wb(1'b1, FLG, 8'h00);
		repeat (4 * h) @(posedge clk_i); // two bit periods before reacquiring
		$display("test conversion %0d done", c);
	endtask

	initial begin
		{cyc_i, stb_i, we_i, trig_i, rst_i} = 5'h01;
		{adr_i, dat_i, compare_mode_i, pin_i, level} = '0;
		sel_i = 4'hF;
		{seed, fails, checked} = {32'h17ED, 64'h0};
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rst_vals();
		wb(1'b0, 10'h001, 8'h00);
		chk("misaligned read", q, 8'h00);
		wb(1'b1, ra(sas_pkg::IDX_PORT_A_DIRECTION), 8'h15);
		wb(1'b0, ra(sas_pkg::IDX_PORT_A_DIRECTION), 8'h00);
		chk("direction", q, 8'h15);
		chk("pin enables", {2'b00, pin_oe_n_o}, 8'h15);
		wb(1'b1, ra(sas_pkg::IDX_PORT_A_PINS), 8'h2A);
		repeat (2) @(posedge clk_i);
		chk("port latch", {2'b00, pin_o}, 8'h2A);
		wb(1'b1, ra(sas_pkg::IDX_PORT_A_DIRECTION), 8'h3F);
		for (int c = 0; c < 8; c++) begin
			seed = xs(seed);
			pin_i <= seed[5:0];
			wb(1'b1, ra(sas_pkg::IDX_ANALOG_PIN_CFG), 8'(c));
			wb(1'b0, ra(sas_pkg::IDX_PORT_A_PINS), 8'h00);
			chk("port read", q, {2'b00, pin_i & ~MASKS[c*6 +: 6]});
		end
		wb(1'b1, ra(sas_pkg::IDX_ANALOG_PIN_CFG), 8'h00);
		$display("test registers done");
		wb(1'b1, CTL, 8'h05); // start in the powering write is refused
		wb(1'b0, CTL, 8'h00);
		chk("start with power on", q, 8'h01);
		for (int c = 0; c < 4; c++) conv(2'(c), 1'b0);
		// trigger run uses the 32-clock source, the fastest one meeting the minimum period
		conv(2'b10, 1'b1);
		trg(4'hA);
		wb(1'b0, CTL, 8'h00);
		chk("other compare mode", {5'h00, q[2:0]}, 8'h01);
		wb(1'b1, CTL, 8'h00);
		trg(sas_pkg::CMP_MODE_SPECIAL);
		wb(1'b0, CTL, 8'h00);
		chk("trigger when off", q, 8'h00);
		wb(1'b1, FLG, 8'h40);
		wb(1'b1, ra(sas_pkg::IDX_PERIPH_IRQ_ENS), 8'h40);
		wb(1'b1, ra(sas_pkg::IDX_GLOBAL_IRQ_CTRL), 8'h40);
		repeat (2) @(posedge clk_i);
		chk("irq no global", 8'(irq_o), 8'h00);
		wb(1'b1, ra(sas_pkg::IDX_GLOBAL_IRQ_CTRL), 8'hC0);
		repeat (2) @(posedge clk_i);
		chk("irq", 8'(irq_o), 8'h01);
		wb(1'b1, FLG, 8'h00);
		repeat (2) @(posedge clk_i);
		chk("irq cleared", 8'(irq_o), 8'h00);
		$display("test interrupt done");
		// rc source again, as in the fourth conversion, for this aborted run, standing in for a sleep conversion
		wb(1'b1, CTL, 8'hC1);
		repeat (40) @(posedge clk_i);
		wb(1'b1, CTL, 8'hC5);
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b1; // reset in mid conversion must leave no flag
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rst_vals();
		end_of_test();
	end
endmodule // testbench
